// >>> verilog/gtc_defs.svh
`ifndef GTC_DEFS_SVH
`define GTC_DEFS_SVH

// Clock source select codes
`define GTC_CS_INSTR   2'h0
`define GTC_CS_SYSTEM  2'h1
`define GTC_CS_EXTPIN  2'h2
`define GTC_CS_LFOSC   2'h3

// Prescale select codes
`define GTC_PS_DIV1    2'h0
`define GTC_PS_DIV2    2'h1
`define GTC_PS_DIV4    2'h2
`define GTC_PS_DIV8    2'h3

// Reset values, counter maximum and 8-bit wrap codes
`define GTC_COUNT_RST  16'h0000
`define GTC_PRE_RST    3'h0
`define GTC_COUNT_MAX  16'hFFFF
`define GTC_WRAP8_FROM 8'hFF
`define GTC_WRAP8_TO   8'h00

// Instruction clock is the system clock divided by four
`define GTC_INSTR_DIV  2'h3

`endif

// >>> verilog/gtc_pkg.sv
package gtc_pkg;
    typedef enum logic [1:0] {
        GTC_SP_IDLE  = 2'b00,
        GTC_SP_WAIT  = 2'b01,
        GTC_SP_PULSE = 2'b10
    } gtc_sp_state_t;
endpackage

// >>> verilog/gtc_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for one level
module gtc_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    logic stage1;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= 1'b0;
            dout   <= 1'b0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

// >>> verilog/gtc_prescaler.sv
`timescale 1ns/1ps
`include "gtc_defs.svh"
// Divide-by-1/2/4/8 of a tick stream; count hidden from software
module gtc_prescaler (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       clear,
    input  wire logic       tick_in,
    input  wire logic [1:0] select,
    output logic            tick_out
);
    logic [2:0] pre;
    logic [2:0] mask;

    // Terminal mask for the selected ratio
    always_comb begin
        unique case (select)
            `GTC_PS_DIV1: mask = 3'h0;
            `GTC_PS_DIV2: mask = 3'h1;
            `GTC_PS_DIV4: mask = 3'h3;
            `GTC_PS_DIV8: mask = 3'h7;
        endcase
    end

    assign tick_out = tick_in && ((pre & mask) == mask);

    // Clear wins so a count-byte write restarts the division
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre <= `GTC_PRE_RST;
        end else if (clear) begin
            pre <= `GTC_PRE_RST;
        end else if (tick_in) begin
            pre <= pre + 3'h1;
        end
    end
endmodule

// >>> verilog/gtc_timer.sv
`timescale 1ns/1ps
`include "gtc_defs.svh"
// What this block does
// - Prescale timer clock by 1, 2, 4, 8
// - Prescaler hidden, cleared by count writes
// - Sync bypass counts external edges directly
// - Unsync external mode counts and wakes in sleep
// - Mode switch may skip or add one
// - Count byte reads always valid
// - Gate active counts, inactive holds count
// - Gate active when level equals polarity
// - Gate source: pin or 8-bit wrap
// - 8-bit wrap FFh to 00h makes pulse
// - Toggle mode flips on gate rising edge
// - Toggle flip-flop cleared while mode off
// - Single pulse armed counts from next edge
// - Trailing edge disarms, blocks further counting
// - Gate level status always readable
// - Gate level fall sets gate event flag
// - Rollover sets flag; interrupt needs four enables
// - Sleep counting only unsync external; wakes
// - Two-bit clock source select
// - Timer-on and gating enable table
// - Count byte writes load counter directly
// - Timer off stops count, clears gate flop
module gtc_timer
    import gtc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             timer_on,
    input  wire logic [1:0]       clock_source_select,
    input  wire logic [1:0]       input_prescale_select,
    input  wire logic             sync_bypass,
    input  wire logic             gating_enable,
    input  wire logic             gate_polarity,
    input  wire logic             gate_toggle_mode,
    input  wire logic             gate_single_pulse_mode,
    input  wire logic             gate_source_select,
    input  wire logic             arm_set,
    input  wire logic             arm_clear,
    input  wire logic             external_clock_pin,
    input  wire logic             low_freq_internal_osc,
    input  wire logic             gate_input_pin,
    input  wire logic [7:0]       eight_bit_timer_count,
    input  wire logic             sleep_mode,
    input  wire logic             count_low_wr,
    input  wire logic             count_high_wr,
    input  wire logic [7:0]       wr_data,
    input  wire logic             rollover_flag_clear,
    input  wire logic             gate_event_flag_clear,
    input  wire logic             rollover_irq_enable,
    input  wire logic             gate_event_irq_enable,
    input  wire logic             peripheral_irq_enable,
    input  wire logic             global_irq_enable,
    output logic [7:0]            count_low_byte,
    output logic [7:0]            count_high_byte,
    output logic                  single_pulse_armed,
    output logic                  gate_level_status,
    output logic                  gate_event_flag,
    output logic                  rollover_flag,
    output logic                  irq,
    output logic                  wake
);
    logic [WIDTH-1:0] count;
    logic [1:0]       instr_div;
    logic             ext_sync;
    logic             gate_pin_sync;
    logic             lfosc_sync;
    logic             ext_prev;
    logic             ext_raw_prev;
    logic             lfosc_prev;
    logic             ext_fall_seen;
    logic [7:0]       t8_prev;
    logic             wrap_pulse;
    logic             gate_src;
    logic             gate_src_prev;
    logic             gate_toggle;
    logic             gate_level;
    logic             gate_prev;
    logic             next_gate_status;
    logic             raw_tick;
    logic             pre_tick;
    logic             count_enable;
    logic             gate_ok;
    logic             count_wr;
    logic             rollover_evt;
    logic             gate_fall_evt;
    logic             ext_edge;
    gtc_sp_state_t    sp_state;

    assign count_wr = count_low_wr || count_high_wr;

    // Synchronisers for external clock, gate pin and slow oscillator
    gtc_sync u_sync_ext (
        .clk  (clk),
        .nrst (nrst),
        .din  (external_clock_pin),
        .dout (ext_sync)
    );
    gtc_sync u_sync_gate (
        .clk  (clk),
        .nrst (nrst),
        .din  (gate_input_pin),
        .dout (gate_pin_sync)
    );
    gtc_sync u_sync_lfosc (
        .clk  (clk),
        .nrst (nrst),
        .din  (low_freq_internal_osc),
        .dout (lfosc_sync)
    );

    // Edge history; ext_raw_prev and t8_prev sample unsynchronised inputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_prev     <= 1'b0;
            ext_raw_prev <= 1'b1; // Idle-high pin gives no false rise after reset
            lfosc_prev   <= 1'b0;
            t8_prev      <= `GTC_WRAP8_TO;
        end else begin
            ext_prev     <= ext_sync;
            ext_raw_prev <= external_clock_pin;
            lfosc_prev   <= lfosc_sync;
            t8_prev    <= eight_bit_timer_count;
        end
    end

    // Instruction clock divider, free running
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            instr_div <= 2'h0;
        end else begin
            instr_div <= instr_div + 2'h1;
        end
    end

    // A falling edge must precede the first counted rising edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_fall_seen <= 1'b0;
        end else if (!timer_on || count_wr) begin
            ext_fall_seen <= 1'b0;
        end else if (sync_bypass ? (ext_raw_prev && !external_clock_pin) : (ext_prev && !ext_sync)) begin
            ext_fall_seen <= 1'b1;
        end
    end

    // Bypass edge-detects the raw pin in one flop, so each rise counts once;
    // switching modes may drop or add one increment
    assign ext_edge = sync_bypass ? (external_clock_pin && !ext_raw_prev)
                                  : (ext_sync && !ext_prev);

    // Clock source selection
    always_comb begin
        unique case (clock_source_select)
            `GTC_CS_INSTR:  raw_tick = (instr_div == `GTC_INSTR_DIV);
            `GTC_CS_SYSTEM: raw_tick = 1'b1;
            `GTC_CS_EXTPIN: raw_tick = ext_edge && ext_fall_seen;
            `GTC_CS_LFOSC:  raw_tick = lfosc_sync && !lfosc_prev;
        endcase
    end

    // Prescaler, cleared on any count-byte write
    gtc_prescaler u_pre (
        .clk      (clk),
        .nrst     (nrst),
        .clear    (count_wr),
        .tick_in  (raw_tick && timer_on),
        .select   (input_prescale_select),
        .tick_out (pre_tick)
    );

    // Wrap pulse from the 8-bit timer
    assign wrap_pulse = (t8_prev == `GTC_WRAP8_FROM) &&
                        (eight_bit_timer_count == `GTC_WRAP8_TO);
    assign gate_src = gate_source_select ? wrap_pulse : gate_pin_sync;

    // Toggle flop; polarity is applied before it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gate_src_prev <= 1'b0;
            gate_toggle   <= 1'b0;
        end else begin
            gate_src_prev <= gate_src ~^ gate_polarity;
            if (!gate_toggle_mode || !timer_on) begin
                gate_toggle <= 1'b0;
            end else if ((gate_src ~^ gate_polarity) && !gate_src_prev) begin
                gate_toggle <= !gate_toggle;
            end
        end
    end

    // Active gate level: polarity match, or toggle output
    logic gate_pol_level;
    assign gate_pol_level = gate_src ~^ gate_polarity;

    // Single-pulse: armed, then a pulse, then done
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sp_state <= GTC_SP_IDLE;
        end else begin
            unique case (sp_state)
                GTC_SP_IDLE: begin
                    if (arm_set) begin
                        sp_state <= GTC_SP_WAIT;
                    end
                end
                GTC_SP_WAIT: begin
                    if (arm_clear) begin
                        sp_state <= GTC_SP_IDLE;
                    end else if (gate_level && !gate_prev) begin
                        sp_state <= GTC_SP_PULSE;
                    end
                end
                GTC_SP_PULSE: begin
                    if (arm_clear || (!gate_level && gate_prev)) begin
                        sp_state <= GTC_SP_IDLE;
                    end
                end
                default: sp_state <= GTC_SP_IDLE;
            endcase
        end
    end

    assign single_pulse_armed = (sp_state != GTC_SP_IDLE);

    // Level seen by the counter, before single-pulse qualification
    always_comb begin
        gate_level = gate_toggle_mode ? gate_toggle : gate_pol_level;
    end

    // Status follows the captured pulse only in single-pulse mode
    assign next_gate_status = gate_single_pulse_mode ? (gate_level && sp_state == GTC_SP_PULSE)
                                                     : gate_level;

    // Gate value status and its history
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gate_prev         <= 1'b0;
            gate_level_status <= 1'b0;
        end else begin
            gate_prev         <= gate_level;
            gate_level_status <= next_gate_status;
        end
    end

    // Gate lets counts through only in the captured pulse in single-pulse mode
    assign gate_ok = gate_single_pulse_mode ? (gate_level && sp_state == GTC_SP_PULSE)
                                            : gate_level;

    // Sleep halts all but unsynchronised external counting
    assign count_enable = timer_on && (!gating_enable || gate_ok) &&
                          (!sleep_mode || (sync_bypass &&
                           clock_source_select == `GTC_CS_EXTPIN));

    assign rollover_evt = pre_tick && count_enable && (count == `GTC_COUNT_MAX);

    // Counter; writes load a byte at once and take priority
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= `GTC_COUNT_RST;
        end else if (count_low_wr) begin
            count[7:0] <= wr_data;
        end else if (count_high_wr) begin
            count[15:8] <= wr_data;
        end else if (pre_tick && count_enable) begin
            count <= count + 16'h0001;
        end
    end

    // Byte views come straight from the counter flops, so reads are clean
    assign count_low_byte  = count[7:0];
    assign count_high_byte = count[15:8];

    // Event tracks the status bit itself, so a disarm mid-pulse also counts
    assign gate_fall_evt = gate_level_status && !next_gate_status;

    // Sticky flags: a new event beats a simultaneous clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rollover_flag   <= 1'b0;
            gate_event_flag <= 1'b0;
        end else begin
            if (rollover_evt) begin
                rollover_flag <= 1'b1;
            end else if (rollover_flag_clear) begin
                rollover_flag <= 1'b0;
            end
            if (gate_fall_evt) begin
                gate_event_flag <= 1'b1;
            end else if (gate_event_flag_clear) begin
                gate_event_flag <= 1'b0;
            end
        end
    end

    // Interrupt and wake requests
    logic ro_req;
    logic ge_req;
    assign ro_req = rollover_flag && rollover_irq_enable && timer_on;
    assign ge_req = gate_event_flag && gate_event_irq_enable;
    assign irq    = (ro_req || ge_req) && peripheral_irq_enable && global_irq_enable;
    assign wake   = sleep_mode && ro_req && peripheral_irq_enable;
endmodule

// >>> verification/gtc_timer_monitor.sv
`timescale 1ns/1ps
// Port-level checks of the gated timer
module gtc_timer_monitor (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       timer_on,
    input wire logic       count_low_wr,
    input wire logic       count_high_wr,
    input wire logic [7:0] wr_data,
    input wire logic       rollover_flag_clear,
    input wire logic       rollover_irq_enable,
    input wire logic       peripheral_irq_enable,
    input wire logic       global_irq_enable,
    input wire logic       sleep_mode,
    input wire logic       arm_set,
    input wire logic       arm_clear,
    input wire logic       gate_single_pulse_mode,
    input wire logic [7:0] count_low_byte,
    input wire logic [7:0] count_high_byte,
    input wire logic       single_pulse_armed,
    input wire logic       gate_level_status,
    input wire logic       gate_event_flag,
    input wire logic       rollover_flag,
    input wire logic       irq,
    input wire logic       wake
);
    logic [15:0] cnt;
    logic        no_wr;
    // Whole count and write-free cycle
    assign cnt = {count_high_byte, count_low_byte};
    assign no_wr = !count_low_wr && !count_high_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Counter wraps while running
    sequence s_wrap;
        (cnt == 16'hFFFF && timer_on) ##1 (cnt == 16'h0000);
    endsequence
    chk_low_load: assert property (
        count_low_wr && !timer_on |=> count_low_byte == $past(wr_data)) else $error("low byte load wrong");
    chk_high_load: assert property (
        count_high_wr && no_wr == 1'b0 && !count_low_wr && !timer_on |=> count_high_byte == $past(wr_data))
        else $error("high byte load wrong");
    chk_off_hold: assert property (
        (!timer_on && no_wr) [*3] |=> $stable(cnt)) else $error("count moved while off");
    chk_step_one: assert property (
        no_wr ##1 (cnt != $past(cnt)) |-> cnt == $past(cnt) + 16'h0001) else $error("count jumped");
    chk_roll_flag: assert property (
        s_wrap |-> ##[0:2] rollover_flag) else $error("rollover flag not set");
    chk_flag_hold: assert property (
        rollover_flag && !rollover_flag_clear |=> rollover_flag) else $error("rollover flag dropped");
    chk_irq_needs: assert property (
        irq |-> global_irq_enable && peripheral_irq_enable) else $error("irq without enables");
    chk_irq_roll: assert property (
        rollover_flag && rollover_irq_enable && timer_on && peripheral_irq_enable && global_irq_enable |-> irq)
        else $error("rollover irq missing");
    chk_wake_eq: assert property (
        wake == (sleep_mode && rollover_flag && rollover_irq_enable && timer_on && peripheral_irq_enable))
        else $error("wake wrong");
    chk_gate_event: assert property (
        $fell(gate_level_status) |-> ##[0:2] gate_event_flag) else $error("gate event flag not set");
    chk_arm_set: assert property (
        arm_set && !arm_clear && gate_single_pulse_mode |=> single_pulse_armed) else $error("arm not set");
    chk_arm_clr: assert property (
        arm_clear && !arm_set |=> !single_pulse_armed) else $error("arm not cleared");
endmodule
bind gtc_timer gtc_timer_monitor mon (.clk, .nrst, .timer_on, .count_low_wr, .count_high_wr, .wr_data,
    .rollover_flag_clear, .rollover_irq_enable, .peripheral_irq_enable, .global_irq_enable, .sleep_mode,
    .arm_set, .arm_clear, .gate_single_pulse_mode, .count_low_byte, .count_high_byte, .single_pulse_armed,
    .gate_level_status, .gate_event_flag, .rollover_flag, .irq, .wake);

// >>> verification/gtc_clk_source.sv
`timescale 1ns/1ps
// External clock source; runs whole periods, stands still between bursts
module gtc_clk_source (
    input  wire logic clk,
    input  wire logic run,
    output logic      ext_clk,
    output logic      busy,
    output int        pulses
);
    // Idles high so each burst opens with a falling edge
    initial begin
        ext_clk = 1'b1;
        busy = 1'b0;
        pulses = 0;
        forever begin
            @(posedge clk);
            #1;
            busy = run;
            if (run) begin
                ext_clk = 1'b0;
                repeat (3) @(posedge clk);
                #1;
                ext_clk = 1'b1; // Counted rising edge
                pulses++;
                repeat (2) @(posedge clk);
            end
        end
    end
endmodule

// >>> verification/gtc_timer_tb.sv
`timescale 1ns/1ps
`include "gtc_defs.svh"
// Self-checking bench for the gated timer
module gtc_timer_tb;
    logic        clk, nrst, timer_on, sync_bypass, gating_enable, gate_polarity, gate_toggle_mode;
    logic        gate_single_pulse_mode, gate_source_select, arm_set, arm_clear, external_clock_pin;
    logic        low_freq_internal_osc, gate_input_pin, sleep_mode, count_low_wr, count_high_wr;
    logic        rollover_flag_clear, gate_event_flag_clear, rollover_irq_enable, gate_event_irq_enable;
    logic        peripheral_irq_enable, global_irq_enable, run, busy, single_pulse_armed;
    logic        gate_level_status, gate_event_flag, rollover_flag, irq, wake;
    logic [1:0]  clock_source_select, input_prescale_select;
    logic [7:0]  eight_bit_timer_count, wr_data, count_low_byte, count_high_byte;
    logic [15:0] cnt, d, v;
    logic [31:0] seed;
    int          err_count, checked, pulses, p0;
    assign cnt = {count_high_byte, count_low_byte};
    gtc_timer #(.WIDTH(16)) uut (.clk, .nrst, .timer_on, .clock_source_select, .input_prescale_select,
        .sync_bypass, .gating_enable, .gate_polarity, .gate_toggle_mode, .gate_single_pulse_mode,
        .gate_source_select, .arm_set, .arm_clear, .external_clock_pin, .low_freq_internal_osc,
        .gate_input_pin, .eight_bit_timer_count, .sleep_mode, .count_low_wr, .count_high_wr, .wr_data,
        .rollover_flag_clear, .gate_event_flag_clear, .rollover_irq_enable, .gate_event_irq_enable,
        .peripheral_irq_enable, .global_irq_enable, .count_low_byte, .count_high_byte, .single_pulse_armed,
        .gate_level_status, .gate_event_flag, .rollover_flag, .irq, .wake);
    gtc_clk_source src (.clk, .run, .ext_clk(external_clock_pin), .busy, .pulses);
    // 50 MHz clock
    initial clk = 1'b0;
    always #10 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Steady-state increments over n clocks
    function automatic logic [15:0] exp_inc(input logic [1:0] cs, input logic [1:0] ps, input int n);
        if (cs == `GTC_CS_LFOSC || cs == `GTC_CS_EXTPIN)
            return 16'h0000; // Oscillator and external pin held still
        return 16'(n / ((cs == `GTC_CS_INSTR) ? 4 : 1) / (1 << ps));
    endfunction
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic delta(input int n);
        v = cnt;
        cyc(n);
        d = cnt - v;
    endtask
    // Timer is stopped by callers first, so no write contention
    task automatic wr16(input logic [15:0] x);
        count_low_wr = 1'b1;
        wr_data = x[7:0];
        cyc(1);
        count_low_wr = 1'b0;
        count_high_wr = 1'b1;
        wr_data = x[15:8];
        cyc(1);
        count_high_wr = 1'b0;
    endtask
    task automatic gpulse;
        gate_input_pin = 1'b1;
        cyc(4);
        gate_input_pin = 1'b0;
        cyc(6);
    endtask
    task automatic conclude;
        $display("Checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        {timer_on, sync_bypass, gating_enable, gate_polarity, gate_toggle_mode, gate_single_pulse_mode,
         gate_source_select, arm_set, arm_clear, low_freq_internal_osc, gate_input_pin, sleep_mode,
         count_low_wr, count_high_wr, rollover_flag_clear, gate_event_flag_clear, rollover_irq_enable,
         gate_event_irq_enable, peripheral_irq_enable, global_irq_enable, run, nrst} = '0;
        clock_source_select = `GTC_CS_SYSTEM;
        input_prescale_select = `GTC_PS_DIV1;
        eight_bit_timer_count = 8'h00;
        wr_data = 8'h00;
        seed = 32'h623D;
        repeat (10) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        cyc(2);
        // Every clock source and prescale code
        timer_on = 1'b1;
        for (int i = 0; i < 16; i++) begin
            {clock_source_select, input_prescale_select} = 4'(i);
            cyc(24);
            delta(64);
            chk("rate", d, exp_inc(clock_source_select, input_prescale_select, 64));
        end
        timer_on = 1'b0;
        cyc(4);
        delta(16);
        chk("off", d, 16'h0000);
        // Random loads, then a same-cycle byte clash
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr16(seed[15:0]);
            chk("load", cnt, seed[15:0]);
        end
        {count_low_wr, count_high_wr} = 2'h3;
        wr_data = ~seed[7:0];
        cyc(1);
        {count_low_wr, count_high_wr} = 2'h0;
        chk("clash", cnt, {seed[15:8], ~seed[7:0]});
        // Byte write restarts the hidden prescaler at a random phase
        clock_source_select = `GTC_CS_SYSTEM;
        input_prescale_select = `GTC_PS_DIV8;
        timer_on = 1'b1;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            cyc(int'(seed[2:0]) + 1);
            count_low_wr = 1'b1;
            wr_data = 8'h10;
            cyc(1);
            count_low_wr = 1'b0;
            cyc(5);
            chk("preclr", 16'(count_low_byte), 16'h0010);
        end
        // Gating, polarity and level status for all combinations
        input_prescale_select = `GTC_PS_DIV1;
        for (int i = 0; i < 8; i++) begin
            {gating_enable, gate_polarity, gate_input_pin} = 3'(i);
            cyc(8);
            delta(16);
            chk("gated", d, (!gating_enable || gate_input_pin == gate_polarity) ? 16'h0010 : 16'h0000);
            chk("status", 16'(gate_level_status), 16'(gate_input_pin == gate_polarity));
        end
        // Wrap pulse as gate source; pin is ignored
        {gate_source_select, gate_event_irq_enable, peripheral_irq_enable, global_irq_enable} = 4'hF;
        eight_bit_timer_count = 8'hFE;
        cyc(6);
        gate_event_flag_clear = 1'b1;
        cyc(1);
        gate_event_flag_clear = 1'b0;
        delta(8);
        chk("nowrap", d, 16'h0000);
        v = cnt;
        eight_bit_timer_count = 8'hFF;
        cyc(1);
        eight_bit_timer_count = 8'h00;
        cyc(8);
        chk("wrap", 16'(cnt != v), 16'h0001);
        chk("gflag", 16'(gate_event_flag), 16'h0001);
        chk("girq", 16'(irq), 16'h0001);
        // Toggle mode with polarity left unchanged
        {gate_source_select, gate_input_pin} = 2'h0;
        cyc(4); // Source switch is itself an edge; settle before toggling
        gate_toggle_mode = 1'b1;
        cyc(4);
        gpulse();
        chk("tog1", 16'(gate_level_status), 16'h0001);
        delta(16);
        chk("togcnt", d, 16'h0010);
        gpulse();
        chk("tog0", 16'(gate_level_status), 16'h0000);
        gpulse();
        gate_toggle_mode = 1'b0;
        cyc(4);
        chk("togclr", 16'(gate_level_status), 16'h0000);
        gate_toggle_mode = 1'b1;
        cyc(2);
        chk("togrst", 16'(gate_level_status), 16'h0000);
        gate_toggle_mode = 1'b0;
        // Single pulse: one pulse counted, the next ignored
        gate_single_pulse_mode = 1'b1;
        arm_set = 1'b1;
        cyc(1);
        arm_set = 1'b0;
        cyc(2);
        chk("armed", 16'(single_pulse_armed), 16'h0001);
        v = cnt;
        gpulse();
        chk("spdone", 16'(single_pulse_armed), 16'h0000);
        chk("spcnt", 16'(cnt != v), 16'h0001);
        delta(0);
        gpulse();
        chk("sphold", cnt - v, 16'h0000);
        arm_set = 1'b1;
        cyc(1);
        arm_set = 1'b0;
        gate_single_pulse_mode = 1'b0;
        arm_clear = 1'b1;
        cyc(1);
        arm_clear = 1'b0;
        gating_enable = 1'b0;
        gate_event_irq_enable = 1'b0; // Gate flag must not mask the rollover irq check
        // External clock, synchronised then bypassed and asleep
        for (int s = 0; s < 2; s++) begin
            timer_on = 1'b0;
            clock_source_select = `GTC_CS_EXTPIN;
            sync_bypass = s[0];
            wr16(16'hFFF8);
            rollover_flag_clear = 1'b1;
            cyc(1);
            rollover_flag_clear = 1'b0;
            rollover_irq_enable = 1'b1;
            timer_on = 1'b1;
            sleep_mode = s[0];
            cyc(4);
            p0 = pulses;
            run = 1'b1;
            cyc(70);
            run = 1'b0;
            for (int k = 0; k < 20 && busy !== 1'b0; k++)
                cyc(1);
            cyc(6);
            chk("ext", cnt, 16'hFFF8 + 16'(pulses - p0));
            chk("roll", 16'(rollover_flag), 16'h0001);
            chk("wake", 16'(wake), 16'(s));
            chk("rirq", 16'(irq), 16'h0001);
            sleep_mode = 1'b0;
        end
        conclude();
    end
endmodule
